// File: logic/wps_pkg.sv
package wps_pkg;

  // ==========================================================================
  // clocking and sample rate
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned SAMPLE_MAX_HZ = 20_000_000;
  // shortest sample period in clocks, rounded up
  localparam int unsigned MIN_DIV_CYC = (CLK_HZ + SAMPLE_MAX_HZ - 1) / SAMPLE_MAX_HZ;
  localparam int DIV_W = 16;
  localparam logic [15:0] MIN_DIV = 16'(MIN_DIV_CYC);

  // ==========================================================================
  // samples
  localparam int SAMPLE_W = 12;
  localparam logic signed [11:0] SAMPLE_MAX = 12'sh7ff;
  localparam logic signed [11:0] SAMPLE_MIN = 12'sh800;
  localparam logic signed [11:0] QUIET_LEVEL = 12'sh000;

  // ==========================================================================
  // waveform numbers and bounds
  localparam int ADDR_W = 17;
  localparam int WAV_W = 7;
  localparam logic [6:0] NUM_USER = 7'h64;
  localparam logic [6:0] NUM_STD = 7'h0a;
  localparam logic [6:0] NUM_WAV = 7'h6e;
  localparam logic [6:0] STD_BASE = 7'h64;
  localparam int STD_SEL_W = 4;

  // ==========================================================================
  // sequence steps and burst
  localparam int STEP_W = 7;
  localparam int NUM_STEPS = 100;
  localparam logic [6:0] NUM_STEPS_C = 7'h64;
  localparam int REP_W = 20;
  localparam logic [19:0] REP_MAX = 20'hf4240;
  localparam int BURST_W = 20;
  localparam logic [19:0] BURST_MIN = 20'h00001;

  // ==========================================================================
  // modes, sources, states
  typedef enum logic [2:0] {
    MODE_CONT   = 3'h0,
    MODE_TRIG   = 3'h1,
    MODE_GATE   = 3'h2,
    MODE_BURST  = 3'h3,
    MODE_TOGGLE = 3'h4,
    MODE_MASTER = 3'h5,
    MODE_SLAVE  = 3'h6
  } wps_mode_t;

  typedef enum logic [1:0] {
    MSUB_CONT_SYNC = 2'h0,
    MSUB_TRIG_SYNC = 2'h1,
    MSUB_TRIG_SEQ  = 2'h2
  } wps_msub_t;

  typedef enum logic [1:0] {
    SRC_STD  = 2'h0,
    SRC_USER = 2'h1,
    SRC_SEQ  = 2'h2
  } wps_src_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN  = 3'b100
  } wps_state_t;

endpackage

// File: logic/wps_play_if.sv
`timescale 1ns/1ns
interface wps_play_if #(
  parameter int ADDR_W = wps_pkg::ADDR_W
);
  logic [wps_pkg::WAV_W-1:0] a_num;
  logic [wps_pkg::WAV_W-1:0] b_num;
  logic [ADDR_W-1:0] a_first;
  logic [ADDR_W-1:0] a_last;
  logic [ADDR_W-1:0] b_first;
  logic [ADDR_W-1:0] b_last;
  logic [wps_pkg::DIV_W-1:0] div;
  logic tick;

  modport player (
    output a_num, b_num, div,
    input a_first, a_last, b_first, b_last, tick
  );
  modport bounds (
    input a_num, b_num,
    output a_first, a_last, b_first, b_last
  );
  modport rate (
    input div,
    output tick
  );
endinterface

// File: logic/wps_bounds.sv
`timescale 1ns/1ns
module wps_bounds #(
  parameter int ADDR_W = wps_pkg::ADDR_W,
  parameter int NUM_WAV = 110
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bound write port
  input wire logic we_i,
  input wire logic [wps_pkg::WAV_W-1:0] num_i,
  input wire logic [ADDR_W-1:0] first_i,
  input wire logic [ADDR_W-1:0] last_i,
  // lookups
  wps_play_if.bounds pif
);

  logic [ADDR_W-1:0] first_ff [NUM_WAV];
  logic [ADDR_W-1:0] last_ff [NUM_WAV];
  logic wr_ok;

  // reversed bounds would run the whole memory, so refuse them
  assign wr_ok = we_i && (last_i >= first_i);

  // ==========================================================================
  // one bound pair per waveform number
  for (genvar g = 0; g < NUM_WAV; g++) begin : g_ent
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        first_ff[g] <= '0;
        last_ff[g] <= '0;
      end else if (wr_ok && (num_i == wps_pkg::WAV_W'(g))) begin
        first_ff[g] <= first_i;
        last_ff[g] <= last_i;
      end
    end
  end

  // ==========================================================================
  // two read ports: current and upcoming waveform
  always_comb begin
    pif.a_first = '0;
    pif.a_last = '0;
    pif.b_first = '0;
    pif.b_last = '0;
    if (32'(pif.a_num) < NUM_WAV) begin
      pif.a_first = first_ff[pif.a_num];
      pif.a_last = last_ff[pif.a_num];
    end
    if (32'(pif.b_num) < NUM_WAV) begin
      pif.b_first = first_ff[pif.b_num];
      pif.b_last = last_ff[pif.b_num];
    end
  end

endmodule

// File: logic/wps_rate.sv
`timescale 1ns/1ns
module wps_rate (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // divisor in, sample tick out
  wps_play_if.rate pif
);

  logic [wps_pkg::DIV_W-1:0] cnt_ff;
  logic [wps_pkg::DIV_W-1:0] eff_div;

  // never faster than the top sample rate
  assign eff_div = (pif.div < wps_pkg::MIN_DIV) ? wps_pkg::MIN_DIV : pif.div;
  assign pif.tick = (cnt_ff == '0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
    end else if (pif.tick) begin
      cnt_ff <= eff_div - 16'h0001;
    end else begin
      cnt_ff <= cnt_ff - 16'h0001;
    end
  end

endmodule

// File: logic/wps_top.sv
`timescale 1ns/1ns
module wps_top #(
  parameter int ADDR_W = wps_pkg::ADDR_W,
  parameter int NUM_STEPS = wps_pkg::NUM_STEPS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // configuration
  input wire logic play_en_i,
  input wire logic [2:0] mode_i,
  input wire logic [1:0] master_sub_i,
  input wire logic [1:0] src_i,
  input wire logic [wps_pkg::WAV_W-1:0] wav_num_i,
  input wire logic [wps_pkg::STD_SEL_W-1:0] std_num_i,
  input wire logic [wps_pkg::BURST_W-1:0] burst_cnt_i,
  input wire logic [wps_pkg::DIV_W-1:0] sclk_div_i,
  // trigger
  input wire logic trig_i,
  input wire logic manual_trig_i,
  // bound table write
  input wire logic bnd_we_i,
  input wire logic [wps_pkg::WAV_W-1:0] bnd_num_i,
  input wire logic [ADDR_W-1:0] bnd_first_i,
  input wire logic [ADDR_W-1:0] bnd_last_i,
  // sequence step write
  input wire logic step_we_i,
  input wire logic [wps_pkg::STEP_W-1:0] step_idx_i,
  input wire logic [wps_pkg::WAV_W-1:0] step_wav_i,
  input wire logic [wps_pkg::REP_W-1:0] step_rep_i,
  // waveform memory
  output logic [ADDR_W-1:0] mem_addr_o,
  input wire logic signed [wps_pkg::SAMPLE_W-1:0] mem_data_i,
  // converter
  output logic signed [wps_pkg::SAMPLE_W-1:0] dac_data_o,
  output logic dac_strobe_o,
  output logic sync_o,
  // status
  output logic running_o,
  output logic seq_empty_o,
  output logic [wps_pkg::STEP_W-1:0] step_count_o,
  output logic [2:0] mode_eff_o,
  output logic step_rej_o
);

  localparam int SW = wps_pkg::STEP_W;
  localparam int RW = wps_pkg::REP_W;

  wps_play_if #(.ADDR_W(ADDR_W)) pif ();

  wps_pkg::wps_state_t state_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [wps_pkg::WAV_W-1:0] cur_wav_ff;
  logic [SW-1:0] step_ff;
  logic [RW-1:0] rep_left_ff;
  logic [wps_pkg::BURST_W-1:0] frames_left_ff;
  logic signed [wps_pkg::SAMPLE_W-1:0] dac_ff;
  logic sync_ff;
  logic trig_prev_ff;
  logic seq_empty_ff;
  logic [SW-1:0] step_count_ff;
  logic [2:0] mode_eff_ff;
  logic step_rej_ff;
  logic [wps_pkg::WAV_W-1:0] step_wav_ff [NUM_STEPS];
  logic [RW-1:0] step_rep_ff [NUM_STEPS];
  logic [NUM_STEPS-1:0] step_vld;

  // ==========================================================================
  // submodules
  wps_bounds #(.ADDR_W(ADDR_W), .NUM_WAV(int'(wps_pkg::NUM_WAV))) u_bounds (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(bnd_we_i),
    .num_i(bnd_num_i),
    .first_i(bnd_first_i),
    .last_i(bnd_last_i),
    .pif(pif.bounds)
  );

  wps_rate u_rate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pif(pif.rate)
  );

  assign pif.div = sclk_div_i;

  // ==========================================================================
  // sequence step table
  logic step_wr_ok;

  assign step_wr_ok = step_we_i && (step_idx_i < wps_pkg::NUM_STEPS_C)
                      && (step_wav_i < wps_pkg::NUM_USER)
                      && (step_rep_i <= wps_pkg::REP_MAX);

  for (genvar g = 0; g < NUM_STEPS; g++) begin : g_step
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        step_wav_ff[g] <= '0;
        step_rep_ff[g] <= '0;
      end else if (step_wr_ok && (step_idx_i == SW'(g))) begin
        step_wav_ff[g] <= step_wav_i;
        step_rep_ff[g] <= step_rep_i;
      end
    end
    // zero repeats means the step is gone
    assign step_vld[g] = (step_rep_ff[g] != '0);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_rej_ff <= 1'b0;
    end else if (step_we_i) begin
      step_rej_ff <= ~step_wr_ok;
    end
  end

  // ==========================================================================
  // step search: first live step, next live step after the current one
  logic [SW-1:0] first_idx;
  logic [SW-1:0] later_idx;
  logic have_later;
  logic [SW-1:0] vcount;
  logic [SW-1:0] tgt_idx;

  always_comb begin
    first_idx = '0;
    later_idx = '0;
    have_later = 1'b0;
    vcount = '0;
    for (int i = NUM_STEPS - 1; i >= 0; i--) begin
      if (step_vld[i]) begin
        first_idx = SW'(i);
        vcount = vcount + 7'h01;
        if (SW'(i) > step_ff) begin
          later_idx = SW'(i);
          have_later = 1'b1;
        end
      end
    end
  end

  // wrap to the first step after the last one
  assign tgt_idx = have_later ? later_idx : first_idx;

  // ==========================================================================
  // mode resolution
  logic is_seq;
  logic [2:0] eff_mode;
  logic [2:0] beh_mode;

  assign is_seq = (src_i == wps_pkg::SRC_SEQ);

  always_comb begin
    eff_mode = mode_i;
    if (is_seq && (mode_i == wps_pkg::MODE_BURST)) begin
      eff_mode = wps_pkg::MODE_TRIG;
    end
    beh_mode = eff_mode;
    if ((eff_mode == wps_pkg::MODE_MASTER) || (eff_mode == wps_pkg::MODE_SLAVE)) begin
      // multi-unit: sync-continuous free runs, the others wait for a trigger
      if (master_sub_i == wps_pkg::MSUB_CONT_SYNC) begin
        beh_mode = wps_pkg::MODE_CONT;
      end else begin
        beh_mode = wps_pkg::MODE_TRIG;
      end
    end
  end

  // ==========================================================================
  // trigger
  logic trig_lvl;
  logic trig_evt;

  assign trig_lvl = trig_i | manual_trig_i;
  assign trig_evt = trig_lvl & ~trig_prev_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_prev_ff <= 1'b0;
    end else begin
      trig_prev_ff <= trig_lvl;
    end
  end

  // ==========================================================================
  // start and continuation decisions
  logic src_ok;
  logic start;
  logic [wps_pkg::WAV_W-1:0] start_wav;
  logic at_last;
  logic step_end;
  logic unit_end;
  logic go_on;
  logic sync_now;

  always_comb begin
    start_wav = wav_num_i;
    src_ok = 1'b0;
    unique case (src_i)
      wps_pkg::SRC_STD: begin
        start_wav = wps_pkg::STD_BASE + 7'(std_num_i);
        src_ok = (7'(std_num_i) < wps_pkg::NUM_STD);
      end
      wps_pkg::SRC_USER: begin
        src_ok = (wav_num_i < wps_pkg::NUM_USER);
      end
      wps_pkg::SRC_SEQ: begin
        start_wav = step_wav_ff[first_idx];
        src_ok = (vcount != '0);
      end
      default: begin
        src_ok = 1'b0;
      end
    endcase
  end

  always_comb begin
    start = 1'b0;
    if (play_en_i && src_ok) begin
      unique case (beh_mode)
        wps_pkg::MODE_CONT: start = 1'b1;
        wps_pkg::MODE_GATE: start = trig_lvl;
        default: start = trig_evt;
      endcase
    end
  end

  assign at_last = (addr_ff == pif.a_last);
  assign step_end = is_seq && (rep_left_ff == 20'h00001);
  // a sequence counts as one frame for the mode logic
  assign unit_end = ~is_seq || (step_end && ~have_later);

  always_comb begin
    go_on = 1'b1;
    if (unit_end) begin
      unique case (beh_mode)
        wps_pkg::MODE_TRIG: go_on = 1'b0;
        wps_pkg::MODE_GATE: go_on = trig_lvl;
        wps_pkg::MODE_BURST: go_on = (frames_left_ff > wps_pkg::BURST_MIN);
        default: go_on = 1'b1;
      endcase
    end
  end

  always_comb begin
    if (is_seq && (vcount > 7'h01)) begin
      sync_now = at_last && step_end && ~have_later;
    end else if (is_seq) begin
      sync_now = (addr_ff == pif.a_first);
    end else begin
      sync_now = (addr_ff == pif.a_first);
    end
  end

  assign pif.a_num = cur_wav_ff;
  assign pif.b_num = step_wav_ff[tgt_idx];

  // ==========================================================================
  // playback sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= wps_pkg::ST_IDLE;
      addr_ff <= '0;
      cur_wav_ff <= '0;
      step_ff <= '0;
      rep_left_ff <= '0;
      frames_left_ff <= '0;
    end else begin
      unique case (state_ff)
        wps_pkg::ST_IDLE: begin
          if (start) begin
            cur_wav_ff <= start_wav;
            step_ff <= first_idx;
            rep_left_ff <= step_rep_ff[first_idx];
            frames_left_ff <= (burst_cnt_i == '0) ? wps_pkg::BURST_MIN : burst_cnt_i;
            state_ff <= wps_pkg::ST_LOAD;
          end
        end
        wps_pkg::ST_LOAD: begin
          // load the address on a tick so the first read settles a full period
          if (!play_en_i) begin
            state_ff <= wps_pkg::ST_IDLE;
          end else if (pif.tick) begin
            addr_ff <= pif.a_first;
            state_ff <= wps_pkg::ST_RUN;
          end
        end
        wps_pkg::ST_RUN: begin
          if (!play_en_i) begin
            state_ff <= wps_pkg::ST_IDLE;
          end else if ((beh_mode == wps_pkg::MODE_TOGGLE) && trig_evt) begin
            state_ff <= wps_pkg::ST_IDLE;
          end else if (pif.tick) begin
            if (!at_last) begin
              addr_ff <= addr_ff + ADDR_W'(1);
            end else if (!go_on) begin
              state_ff <= wps_pkg::ST_IDLE;
            end else begin
              if (unit_end && (frames_left_ff > wps_pkg::BURST_MIN)) begin
                frames_left_ff <= frames_left_ff - 20'h00001;
              end
              if (step_end) begin
                addr_ff <= pif.b_first;
                cur_wav_ff <= pif.b_num;
                step_ff <= tgt_idx;
                rep_left_ff <= step_rep_ff[tgt_idx];
              end else begin
                addr_ff <= pif.a_first;
                if (is_seq) begin
                  rep_left_ff <= rep_left_ff - 20'h00001;
                end
              end
            end
          end
        end
        default: begin
          state_ff <= wps_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // converter data and sync
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dac_ff <= wps_pkg::QUIET_LEVEL;
      sync_ff <= 1'b0;
    end else if (state_ff != wps_pkg::ST_RUN) begin
      if (pif.tick || !play_en_i) begin
        dac_ff <= wps_pkg::QUIET_LEVEL;
        sync_ff <= 1'b0;
      end
    end else if (!play_en_i || ((beh_mode == wps_pkg::MODE_TOGGLE) && trig_evt)) begin
      dac_ff <= wps_pkg::QUIET_LEVEL;
      sync_ff <= 1'b0;
    end else if (pif.tick) begin
      dac_ff <= mem_data_i;
      sync_ff <= sync_now;
    end
  end

  // ==========================================================================
  // status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_empty_ff <= 1'b1;
      step_count_ff <= '0;
      mode_eff_ff <= wps_pkg::MODE_CONT;
    end else begin
      seq_empty_ff <= (vcount == '0);
      step_count_ff <= vcount;
      mode_eff_ff <= eff_mode;
    end
  end

  assign mem_addr_o = addr_ff;
  assign dac_data_o = dac_ff;
  assign dac_strobe_o = pif.tick;
  assign sync_o = sync_ff;
  assign running_o = (state_ff != wps_pkg::ST_IDLE);
  assign seq_empty_o = seq_empty_ff;
  assign step_count_o = step_count_ff;
  assign mode_eff_o = mode_eff_ff;
  assign step_rej_o = step_rej_ff;

endmodule

// File: verification/wps_top_properties.sv
`timescale 1ns/1ns
module wps_top_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // configuration
  input wire logic play_en_i,
  input wire logic [2:0] mode_i,
  input wire logic [1:0] src_i,
  input wire logic step_we_i,
  input wire logic [6:0] step_wav_i,
  input wire logic [19:0] step_rep_i,
  // watched outputs
  input wire logic signed [11:0] dac_data_o,
  input wire logic dac_strobe_o,
  input wire logic sync_o,
  input wire logic running_o,
  input wire logic seq_empty_o,
  input wire logic [6:0] step_count_o,
  input wire logic [2:0] mode_eff_o,
  input wire logic step_rej_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================================
  // playback timing
  chk_dac_on_tick: assert property (!$stable(dac_data_o) |-> $past(dac_strobe_o) || !running_o)
    else $error("dac data changed between ticks");
  chk_sync_on_tick: assert property (!$stable(sync_o) |-> $past(dac_strobe_o) || !running_o)
    else $error("sync changed between ticks");
  chk_tick_spacing: assert property (dac_strobe_o |=> !dac_strobe_o [*6])
    else $error("sample ticks closer than minimum period");
  chk_cont_holds: assert property (running_o && play_en_i && mode_i == 3'h0 |=> running_o)
    else $error("continuous playback stopped");
  chk_stop_quiet: assert property (running_o && !play_en_i |=> !running_o && !sync_o && dac_data_o == 12'sh000)
    else $error("output not quiet after stop");

  // ==========================================================================
  // modes and steps
  chk_burst_fixup: assert property (mode_i == 3'h3 && src_i == 2'h2 |=> mode_eff_o == 3'h1)
    else $error("burst with sequence not turned to trigger");
  chk_burst_keep: assert property (mode_i == 3'h3 && src_i != 2'h2 |=> mode_eff_o == 3'h3)
    else $error("burst mode lost without sequence");
  chk_std_refused: assert property (step_we_i && step_wav_i >= wps_pkg::NUM_USER |=> step_rej_o)
    else $error("standard waveform accepted as step");
  chk_rep_limit: assert property (step_we_i && step_rep_i > wps_pkg::REP_MAX |=> step_rej_o)
    else $error("repeat count above limit accepted");
  chk_empty_flag: assert property (seq_empty_o == (step_count_o == 7'h00))
    else $error("empty flag disagrees with step count");
  chk_step_limit: assert property (step_count_o <= wps_pkg::NUM_STEPS_C)
    else $error("step count above limit");

  cov_sync: cover property ($rose(sync_o));
  cov_stop: cover property ($fell(running_o));
  cov_reject: cover property ($rose(step_rej_o));
endmodule

bind wps_top wps_top_properties i_chk (
  .clk_i, .rst_i, .play_en_i, .mode_i, .src_i, .step_we_i, .step_wav_i, .step_rep_i,
  .dac_data_o, .dac_strobe_o, .sync_o, .running_o, .seq_empty_o, .step_count_o,
  .mode_eff_o, .step_rej_o
);

// File: verification/wps_mem_model.sv
`timescale 1ns/1ns
module wps_mem_model #(
  parameter int LAT = 1
) (
  // clock
  input wire logic clk_i,
  // memory port
  input wire logic [16:0] addr_i,
  output logic signed [11:0] data_o
);
  // ==========================================================================
  // read pipeline, LAT clocks deep, sample is the low 6 address bits and their inverse
  logic signed [11:0] pipe [0:7];
  always_ff @(posedge clk_i) begin
    pipe[0] <= {addr_i[5:0], ~addr_i[5:0]};
    for (int i = 1; i < 8; i++) begin
      pipe[i] <= pipe[i - 1];
    end
  end
  assign data_o = pipe[LAT - 1];
endmodule

// File: verification/wps_top_bench.sv
`timescale 1ns/1ns
module wps_top_bench;
  logic clk_i, rst_i, play_en_i, trig_i, manual_trig_i, bnd_we_i, step_we_i;
  logic [2:0] mode_i, mode_eff_o;
  logic [1:0] master_sub_i, src_i;
  logic [6:0] wav_num_i, bnd_num_i, step_idx_i, step_wav_i, step_count_o;
  logic [3:0] std_num_i;
  logic [19:0] burst_cnt_i, step_rep_i;
  logic [15:0] sclk_div_i;
  logic [16:0] bnd_first_i, bnd_last_i, mem_addr_o;
  logic signed [11:0] mem_data_i, dac_data_o;
  logic dac_strobe_o, sync_o, running_o, seq_empty_o, step_rej_o;
  int fail_count, checks, ne, n;
  logic [16:0] ea [0:15];
  logic es [0:15];

  wps_top i_dut (.clk_i, .rst_i, .play_en_i, .mode_i, .master_sub_i, .src_i, .wav_num_i,
    .std_num_i, .burst_cnt_i, .sclk_div_i, .trig_i, .manual_trig_i, .bnd_we_i, .bnd_num_i,
    .bnd_first_i, .bnd_last_i, .step_we_i, .step_idx_i, .step_wav_i, .step_rep_i,
    .mem_addr_o, .mem_data_i, .dac_data_o, .dac_strobe_o, .sync_o, .running_o,
    .seq_empty_o, .step_count_o, .mode_eff_o, .step_rej_o);
  wps_mem_model #(.LAT(3)) i_mem (.clk_i, .addr_i(mem_addr_o), .data_o(mem_data_i));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // ==========================================================================
  // helpers
  function automatic logic [31:0] smp(input logic [16:0] a);
    return {20'h0, a[5:0], ~a[5:0]};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // waits for a sample tick, returns once its sample is on the converter
  task automatic tick();
    int k = 0;
    while (dac_strobe_o !== 1'b1) begin
      @(negedge clk_i);
      k++;
      if (k > 40) begin
        fail_count++;
        report_and_stop();
      end
    end
    @(posedge clk_i);
    #1;
  endtask

  task automatic wbnd(input logic [6:0] w, input logic [16:0] f, input logic [16:0] l);
    @(posedge clk_i);
    bnd_we_i <= 1'b1;
    bnd_num_i <= w;
    bnd_first_i <= f;
    bnd_last_i <= l;
    @(posedge clk_i);
    bnd_we_i <= 1'b0;
  endtask

  task automatic wstep(input logic [6:0] i, input logic [6:0] w, input logic [19:0] r,
                       input logic rej);
    @(posedge clk_i);
    step_we_i <= 1'b1;
    step_idx_i <= i;
    step_wav_i <= w;
    step_rep_i <= r;
    @(posedge clk_i);
    step_we_i <= 1'b0;
    #1;
    cmp("step_rej", {31'h0, rej}, {31'h0, step_rej_o});
  endtask

  // external trigger pulse two clocks wide, low again for one clock before returning
  task automatic pulse();
    @(posedge clk_i);
    trig_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    trig_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  task automatic start(input logic [2:0] m, input logic [1:0] s);
    @(posedge clk_i);
    mode_i <= m;
    src_i <= s;
    play_en_i <= 1'b1;
  endtask

  task automatic stop();
    @(posedge clk_i);
    play_en_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    cmp("running", 32'h0, {31'h0, running_o});
    cmp("dac_data", 32'h0, {20'h0, dac_data_o});
  endtask

  // appends one frame of expected samples
  task automatic fr(input logic [16:0] f, input logic [16:0] l, input logic sf, input logic sl);
    for (logic [16:0] a = f; a <= l; a++) begin
      ea[ne] = a;
      es[ne] = (a == f && sf) || (a == l && sl);
      ne++;
    end
  endtask

  // aligns on a sync pulse, then compares the expected sample list
  task automatic check_seq();
    int k;
    for (k = 0; k < 40 && sync_o !== 1'b1; k++) tick();
    for (k = 0; k < ne; k++) begin
      if (k > 0) tick();
      cmp("dac_data", smp(ea[k]), {20'h0, dac_data_o});
      cmp("sync", {31'h0, es[k]}, {31'h0, sync_o});
    end
    ne = 0;
  endtask

  // counts sync pulses until playback ends; poke raises a second trigger mid-run
  task automatic runout(input logic poke, output int ns);
    int i;
    ns = 0;
    for (i = 0; i < 200 && running_o === 1'b1; i++) begin
      tick();
      if (sync_o === 1'b1) ns++;
      if (i == 1) manual_trig_i <= poke;
      if (i == 2) manual_trig_i <= 1'b0;
    end
    if (i == 200) begin
      fail_count++;
      report_and_stop();
    end
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    {play_en_i, trig_i, manual_trig_i, bnd_we_i, step_we_i} = '0;
    {mode_i, master_sub_i, src_i, bnd_num_i, bnd_first_i, bnd_last_i} = '0;
    {step_idx_i, step_wav_i, step_rep_i} = '0;
    wav_num_i = 7'h05;
    std_num_i = 4'h2;
    burst_cnt_i = 20'h00003;
    sclk_div_i = 16'h0007;
    {checks, fail_count, ne} = '0;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    cmp("seq_empty", 32'h1, {31'h0, seq_empty_o});
    cmp("running", 32'h0, {31'h0, running_o});
    wbnd(7'h05, 17'h28, 17'h2b);
    wbnd(7'h06, 17'h08, 17'h09);
    wbnd(7'h66, 17'h14, 17'h16);
    start(3'h0, 2'h1);
    fr(17'h28, 17'h2b, 1'b1, 1'b0);
    fr(17'h28, 17'h2b, 1'b1, 1'b0);
    check_seq();
    stop();
    start(3'h0, 2'h0);
    fr(17'h14, 17'h16, 1'b1, 1'b0);
    fr(17'h14, 17'h16, 1'b1, 1'b0);
    check_seq();
    stop();
    start(3'h1, 2'h1);
    pulse();
    runout(1'b1, n);
    cmp("frames", 32'h1, 32'(n));
    start(3'h3, 2'h1);
    pulse();
    runout(1'b1, n);
    cmp("frames", 32'h3, 32'(n));
    burst_cnt_i <= 20'h00001;
    pulse();
    runout(1'b0, n);
    cmp("frames", 32'h1, 32'(n));
    start(3'h2, 2'h1);
    manual_trig_i <= 1'b1;
    repeat (12) tick();
    cmp("running", 32'h1, {31'h0, running_o});
    manual_trig_i <= 1'b0;
    runout(1'b0, n);
    start(3'h4, 2'h1);
    pulse();
    repeat (10) tick();
    cmp("running", 32'h1, {31'h0, running_o});
    pulse();
    cmp("running", 32'h0, {31'h0, running_o});
    cmp("dac_data", 32'h0, {20'h0, dac_data_o});
    stop();
    wstep(7'h00, 7'h05, 20'h00002, 1'b0);
    wstep(7'h01, 7'h06, 20'h00001, 1'b0);
    wstep(7'h02, 7'h64, 20'h00001, 1'b1);
    wstep(7'h02, 7'h05, 20'hf4241, 1'b1);
    wstep(7'h64, 7'h05, 20'h00001, 1'b1);
    wstep(7'h63, 7'h06, 20'hf4240, 1'b0);
    wstep(7'h63, 7'h06, 20'h00000, 1'b0);
    @(posedge clk_i);
    #1;
    cmp("step_count", 32'h2, {25'h0, step_count_o});
    start(3'h0, 2'h2);
    fr(17'h09, 17'h09, 1'b1, 1'b1);
    fr(17'h28, 17'h2b, 1'b0, 1'b0);
    fr(17'h28, 17'h2b, 1'b0, 1'b0);
    fr(17'h08, 17'h09, 1'b0, 1'b1);
    check_seq();
    stop();
    wstep(7'h01, 7'h06, 20'h00000, 1'b0);
    start(3'h0, 2'h2);
    fr(17'h28, 17'h2b, 1'b1, 1'b0);
    fr(17'h28, 17'h2b, 1'b1, 1'b0);
    check_seq();
    stop();
    burst_cnt_i <= 20'h00003;
    start(3'h3, 2'h2);
    repeat (2) @(posedge clk_i);
    #1;
    cmp("mode_eff", 32'h1, {29'h0, mode_eff_o});
    pulse();
    runout(1'b0, n);
    cmp("syncs", 32'h2, 32'(n));
    stop();
    for (int m = 5; m < 7; m++) begin
      master_sub_i <= 2'h0;
      start(3'(m), 2'h1);
      repeat (3) @(posedge clk_i);
      #1;
      cmp("running", 32'h1, {31'h0, running_o});
      stop();
      master_sub_i <= 2'h1;
      start(3'(m), 2'h1);
      repeat (5) @(posedge clk_i);
      #1;
      cmp("running", 32'h0, {31'h0, running_o});
      pulse();
      runout(1'b0, n);
      cmp("frames", 32'h1, 32'(n));
      stop();
    end
    wstep(7'h00, 7'h05, 20'h00000, 1'b0);
    @(posedge clk_i);
    #1;
    cmp("seq_empty", 32'h1, {31'h0, seq_empty_o});
    report_and_stop();
  end
endmodule
